// *** rtl/urt_defines.svh ***
// register offsets, field positions, reset values of the serial core
`ifndef URT_DEFINES_SVH
`define URT_DEFINES_SVH
`define URT_OFS_MODE 8'h00
`define URT_OFS_CTRL 8'h04
`define URT_OFS_DIV 8'h08
`define URT_OFS_TXBUF 8'h0c
`define URT_OFS_RXBUF 8'h10
`define URT_OFS_ERR 8'h14
`define URT_OFS_TSTAT 8'h18
`define URT_MODE_RST 8'h01
`define URT_CTRL_RST 2'h2
`define URT_DIV_RST 8'hff
`define URT_RXBUF_RST 8'hff
`define URT_DIV_MIN 8'h08
`define URT_CTRL_DIR 1
`define URT_TST_FULL 1
`define URT_TST_BUSY 0
`define URT_ERR_OVE 0
`define URT_ERR_FE 1
`define URT_ERR_PE 2
`endif

// *** rtl/urt_pkg.sv ***
// types of the serial core
package urt_pkg;
	typedef enum logic [1:0] {
		URT_PAR_NONE = 2'b00,
		URT_PAR_ZERO = 2'b01,
		URT_PAR_ODD = 2'b10,
		URT_PAR_EVEN = 2'b11
	} urt_par_t;
	typedef struct packed {
		logic power;
		logic tx_en;
		logic rx_en;
		urt_par_t par;
		logic len8;
		logic stop2;
		logic irq_split;
	} urt_mode_t;
	typedef enum logic [2:0] {
		URT_TX_IDLE = 3'b000,
		URT_TX_START = 3'b001,
		URT_TX_DATA = 3'b010,
		URT_TX_PAR = 3'b011,
		URT_TX_STOP1 = 3'b100,
		URT_TX_STOP2 = 3'b101
	} urt_tx_st_t;
	typedef enum logic [2:0] {
		URT_RX_IDLE = 3'b000,
		URT_RX_START = 3'b001,
		URT_RX_DATA = 3'b010,
		URT_RX_PAR = 3'b011,
		URT_RX_STOP = 3'b100
	} urt_rx_st_t;
endpackage

// *** rtl/urt_core.sv ***
// asynchronous serial transmit and receive core with apb registers
// Notes on behaviour
// - even parity: transmit parity bit 1 when data has odd ones
// - even parity: receive error when data plus parity has odd ones
// - odd parity: transmit parity bit 0 when data has odd ones
// - odd parity: receive error when data plus parity has even ones
// - zero parity sends 0 and ignores; no parity omits; never errors
// - power then tx enable; a buffer write starts a frame
// - buffer moves to shift register; start, parity, stops added
// - transmit done pulse right after the last stop bit
// - buffer accepts next byte once shifting starts; no gaps
// - status bit 1 shows buffer holds unmoved data
// - status bit 0 shows a frame is being shifted out
// - flags pass 10, 11, 01 after a write to the idle transmitter; back-to-back frames go 11, 01
// - falling edge starts counter; low at divisor means start bit
// - after stop: done or error pulse, buffer copy unless overrun
// - parity error does not abort; reported at frame end
// - only one stop bit is checked
// - parity, framing and overrun errors are flagged
// - reading error status clears the error flags
// - errors raise an error interrupt while split bit 0 is clear; when it is set they pulse done instead
// - receive input filtered by two agreeing samples
// - frame: start, 7 or 8 bits, optional parity, 1 or 2 stops
// - bit order lsb or msb first by a control bit
// - clearing tx or rx enable resets that circuit
`timescale 1ns/10ps
`include "urt_defines.svh"

module urt_core #(
	parameter int AW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	output logic tx_done_irq,
	output logic rx_done_irq,
	output logic rx_error_irq
);

	if (AW < 5) begin : g_bad_aw
		$error("address too narrow for the register map");
	end

	////////////////////////////////////////////////////////////////////
	// helpers

	// bit period minus one, divisor held at its floor
	function automatic logic [8:0] f_period(input logic [7:0] d);
		logic [7:0] c;
		c = (d < `URT_DIV_MIN) ? `URT_DIV_MIN : d;
		return {c, 1'b1} - 9'h002;
	endfunction

	// half period minus one, the start bit re-sample point
	function automatic logic [8:0] f_half(input logic [7:0] d);
		logic [7:0] c;
		c = (d < `URT_DIV_MIN) ? `URT_DIV_MIN : d;
		return {1'b0, c} - 9'h001;
	endfunction

	// xor of the character bits
	function automatic logic f_ones(input logic [7:0] d, input logic l8);
		return ^(l8 ? d : {1'b0, d[6:0]});
	endfunction

	// position in the shift register of serial bit i
	function automatic logic [2:0] f_pos(input logic [2:0] i,
			input logic l8, input logic lsb);
		logic [2:0] top;
		top = l8 ? 3'h7 : 3'h6;
		return lsb ? i : 3'(top - i);
	endfunction

	////////////////////////////////////////////////////////////////////
	// register bus

	urt_pkg::urt_mode_t mode;
	logic [1:0] ctrl;
	logic [7:0] baud_divisor_reg;
	logic [7:0] tx_buffer;
	logic [7:0] tx_shift_reg;
	logic [7:0] rx_shift_reg;
	logic [7:0] rx_buffer;
	logic [2:0] rx_error_status;
	logic tx_buffer_full_flag;
	logic tx_shift_busy_flag;
	logic rx_unread;
	logic [31:0] rd_mux;
	logic hit;

	wire acc = psel & penable & ~pready;
	wire done = psel & penable & pready;
	wire wr = done & pwrite & ~pslverr;
	wire rd = done & ~pwrite & ~pslverr;
	wire lsb_first = ctrl[`URT_CTRL_DIR];
	wire [7:0] ofs = 8'(paddr);
	wire [7:0] transmit_status = {6'h00, tx_buffer_full_flag,
		tx_shift_busy_flag};

	// read data and decode
	always_comb begin
		hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (ofs)
			`URT_OFS_MODE: rd_mux = {24'h00_0000, mode};
			`URT_OFS_CTRL: rd_mux = {30'h0000_0000, ctrl};
			`URT_OFS_DIV: rd_mux = {24'h00_0000, baud_divisor_reg};
			`URT_OFS_TXBUF: rd_mux = {24'h00_0000, tx_buffer};
			`URT_OFS_RXBUF: rd_mux = {24'h00_0000, rx_buffer};
			`URT_OFS_ERR: rd_mux = {29'h0000_0000, rx_error_status};
			`URT_OFS_TSTAT: rd_mux = {24'h00_0000, transmit_status};
			default: hit = 1'b0;
		endcase
	end

	// one wait state, answer held through the pready cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= acc;
			pslverr <= acc & ~hit;
			if (acc)
				prdata <= pwrite ? 32'h0000_0000 : rd_mux;
		end
	end

	// control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= `URT_MODE_RST;
			ctrl <= `URT_CTRL_RST;
			baud_divisor_reg <= `URT_DIV_RST;
		end else if (wr) begin
			if (ofs == `URT_OFS_MODE)
				mode <= pwdata[7:0];
			if (ofs == `URT_OFS_CTRL)
				ctrl <= pwdata[1:0];
			if (ofs == `URT_OFS_DIV)
				baud_divisor_reg <= pwdata[7:0];
		end
	end

	wire tb_wr = wr & (ofs == `URT_OFS_TXBUF);
	wire err_rd = rd & (ofs == `URT_OFS_ERR);
	wire rxb_rd = rd & (ofs == `URT_OFS_RXBUF);

	////////////////////////////////////////////////////////////////////
	// transmitter

	urt_pkg::urt_tx_st_t tx_st;
	logic [8:0] tx_tmr;
	logic [2:0] tx_idx;
	wire tx_on = mode.power & mode.tx_en;
	wire tx_tick = tx_tmr == f_period(baud_divisor_reg);
	wire [2:0] tx_last = mode.len8 ? 3'h7 : 3'h6;
	wire tx_ones = f_ones(tx_shift_reg, mode.len8);
	wire tx_last_stop = tx_tick &
		((tx_st == urt_pkg::URT_TX_STOP1 && !mode.stop2) ||
		tx_st == urt_pkg::URT_TX_STOP2);

	// frame sequencer; enable low resets it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st <= urt_pkg::URT_TX_IDLE;
			tx_tmr <= 9'h000;
			tx_idx <= 3'h0;
			tx_shift_reg <= 8'h00;
			tx_buffer <= 8'h00;
			tx_buffer_full_flag <= 1'b0;
			tx_shift_busy_flag <= 1'b0;
			serial_out_pin <= 1'b1;
			tx_done_irq <= 1'b0;
		end else if (!tx_on) begin
			tx_st <= urt_pkg::URT_TX_IDLE;
			tx_tmr <= 9'h000;
			tx_idx <= 3'h0;
			tx_buffer_full_flag <= 1'b0;
			tx_shift_busy_flag <= 1'b0;
			serial_out_pin <= 1'b1;
			tx_done_irq <= 1'b0;
		end else begin
			tx_done_irq <= 1'b0;
			tx_tmr <= tx_tick ? 9'h000 : 9'(tx_tmr + 9'h001);
			if (tx_last_stop) begin
				tx_done_irq <= 1'b1;
				if (tx_buffer_full_flag) begin
					tx_shift_reg <= tx_buffer;
					tx_st <= urt_pkg::URT_TX_START;
					serial_out_pin <= 1'b0;
				end else begin
					tx_st <= urt_pkg::URT_TX_IDLE;
					tx_shift_busy_flag <= 1'b0;
				end
			end else begin
				unique case (tx_st)
					urt_pkg::URT_TX_IDLE: begin
						serial_out_pin <= 1'b1;
						tx_tmr <= 9'h000;
						if (tx_buffer_full_flag) begin
							tx_shift_reg <= tx_buffer;
							tx_st <= urt_pkg::URT_TX_START;
							tx_shift_busy_flag <= 1'b1;
							serial_out_pin <= 1'b0;
						end
					end
					urt_pkg::URT_TX_START: begin
						if (tx_tmr == 9'h000)
							tx_buffer_full_flag <= 1'b0;
						if (tx_tick) begin
							tx_st <= urt_pkg::URT_TX_DATA;
							tx_idx <= 3'h0;
							serial_out_pin <= tx_shift_reg[f_pos(3'h0,
								mode.len8, lsb_first)];
						end
					end
					urt_pkg::URT_TX_DATA: begin
						if (tx_tick && tx_idx == tx_last) begin
							unique case (mode.par)
								urt_pkg::URT_PAR_NONE: begin
									tx_st <= urt_pkg::URT_TX_STOP1;
									serial_out_pin <= 1'b1;
								end
								urt_pkg::URT_PAR_ZERO: begin
									tx_st <= urt_pkg::URT_TX_PAR;
									serial_out_pin <= 1'b0;
								end
								urt_pkg::URT_PAR_ODD: begin
									tx_st <= urt_pkg::URT_TX_PAR;
									serial_out_pin <= ~tx_ones;
								end
								urt_pkg::URT_PAR_EVEN: begin
									tx_st <= urt_pkg::URT_TX_PAR;
									serial_out_pin <= tx_ones;
								end
							endcase
						end else if (tx_tick) begin
							tx_idx <= 3'(tx_idx + 3'h1);
							serial_out_pin <= tx_shift_reg[f_pos(
								3'(tx_idx + 3'h1), mode.len8, lsb_first)];
						end
					end
					urt_pkg::URT_TX_PAR: begin
						if (tx_tick) begin
							tx_st <= urt_pkg::URT_TX_STOP1;
							serial_out_pin <= 1'b1;
						end
					end
					urt_pkg::URT_TX_STOP1: begin
						if (tx_tick)
							tx_st <= urt_pkg::URT_TX_STOP2;
					end
					urt_pkg::URT_TX_STOP2: begin
						serial_out_pin <= 1'b1;
					end
					default: tx_st <= urt_pkg::URT_TX_IDLE;
				endcase
			end
			// a write wins over the clear in the same cycle
			if (tb_wr) begin
				tx_buffer <= pwdata[7:0];
				tx_buffer_full_flag <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// receive filter and receiver

	logic rx_s0;
	logic rx_s1;
	logic rx_filt;
	logic rx_filt_q;
	urt_pkg::urt_rx_st_t rx_st;
	logic [8:0] rx_tmr;
	logic [2:0] rx_idx;
	logic rx_pe;
	wire rx_on = mode.power & mode.rx_en;
	wire rx_tick = rx_tmr == f_period(baud_divisor_reg);
	wire rx_fall = rx_filt_q & ~rx_filt;
	wire rx_ones = f_ones(rx_shift_reg, mode.len8) ^ rx_filt;
	wire [2:0] rx_last = mode.len8 ? 3'h7 : 3'h6;

	// two agreeing samples move the filter output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_s0 <= 1'b1;
			rx_s1 <= 1'b1;
			rx_filt <= 1'b1;
			rx_filt_q <= 1'b1;
		end else if (!mode.power) begin
			rx_s0 <= 1'b1;
			rx_s1 <= 1'b1;
			rx_filt <= 1'b1;
			rx_filt_q <= 1'b1;
		end else begin
			rx_s0 <= serial_in_pin;
			rx_s1 <= rx_s0;
			if (rx_s0 == rx_s1)
				rx_filt <= rx_s1;
			rx_filt_q <= rx_filt;
		end
	end

	// frame sequencer, error flags and receive buffer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st <= urt_pkg::URT_RX_IDLE;
			rx_tmr <= 9'h000;
			rx_idx <= 3'h0;
			rx_pe <= 1'b0;
			rx_shift_reg <= 8'h00;
			rx_buffer <= `URT_RXBUF_RST;
			rx_error_status <= 3'h0;
			rx_unread <= 1'b0;
			rx_done_irq <= 1'b0;
			rx_error_irq <= 1'b0;
		end else if (!mode.power) begin
			rx_st <= urt_pkg::URT_RX_IDLE;
			rx_tmr <= 9'h000;
			rx_buffer <= `URT_RXBUF_RST;
			rx_error_status <= 3'h0;
			rx_unread <= 1'b0;
			rx_done_irq <= 1'b0;
			rx_error_irq <= 1'b0;
		end else begin
			rx_done_irq <= 1'b0;
			rx_error_irq <= 1'b0;
			// only flags that were reported are cleared
			rx_error_status <= rx_error_status &
				~(err_rd ? prdata[2:0] : 3'h0);
			rx_unread <= rx_unread & ~rxb_rd;
			rx_tmr <= 9'(rx_tmr + 9'h001);
			if (!mode.rx_en) begin
				rx_st <= urt_pkg::URT_RX_IDLE;
				rx_tmr <= 9'h000;
			end else begin
				unique case (rx_st)
					urt_pkg::URT_RX_IDLE: begin
						rx_tmr <= 9'h000;
						if (rx_fall)
							rx_st <= urt_pkg::URT_RX_START;
					end
					urt_pkg::URT_RX_START: begin
						if (rx_tmr == f_half(baud_divisor_reg)) begin
							rx_tmr <= 9'h000;
							rx_idx <= 3'h0;
							rx_pe <= 1'b0;
							rx_shift_reg <= 8'h00;
							rx_st <= rx_filt ? urt_pkg::URT_RX_IDLE :
								urt_pkg::URT_RX_DATA;
						end
					end
					urt_pkg::URT_RX_DATA: begin
						if (rx_tick) begin
							rx_tmr <= 9'h000;
							rx_shift_reg[f_pos(rx_idx, mode.len8,
								lsb_first)] <= rx_filt;
							rx_idx <= 3'(rx_idx + 3'h1);
							if (rx_idx == rx_last)
								rx_st <= (mode.par == urt_pkg::URT_PAR_NONE) ?
									urt_pkg::URT_RX_STOP : urt_pkg::URT_RX_PAR;
						end
					end
					urt_pkg::URT_RX_PAR: begin
						if (rx_tick) begin
							rx_tmr <= 9'h000;
							rx_st <= urt_pkg::URT_RX_STOP;
							unique case (mode.par)
								urt_pkg::URT_PAR_EVEN: rx_pe <= rx_ones;
								urt_pkg::URT_PAR_ODD: rx_pe <= ~rx_ones;
								default: rx_pe <= 1'b0;
							endcase
						end
					end
					urt_pkg::URT_RX_STOP: begin
						if (rx_tick) begin
							// one stop bit only
							rx_st <= urt_pkg::URT_RX_IDLE;
							rx_error_status[`URT_ERR_PE] <= rx_pe;
							rx_error_status[`URT_ERR_FE] <= ~rx_filt;
							rx_error_status[`URT_ERR_OVE] <= rx_unread;
							if (!rx_unread) begin
								rx_buffer <= rx_shift_reg;
								rx_unread <= 1'b1;
							end
							if ((rx_pe | ~rx_filt | rx_unread) &&
									!mode.irq_split)
								rx_error_irq <= 1'b1;
							else
								rx_done_irq <= 1'b1;
						end
					end
					default: rx_st <= urt_pkg::URT_RX_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_idle_pin_high: assert property (
		tx_st == urt_pkg::URT_TX_IDLE |-> serial_out_pin)
		else $error("transmit pin low while idle");
	chk_even_par_bit: assert property (
		tx_st == urt_pkg::URT_TX_PAR && mode.par == urt_pkg::URT_PAR_EVEN
		|-> serial_out_pin == ^(mode.len8 ? tx_shift_reg :
			{1'b0, tx_shift_reg[6:0]}))
		else $error("even parity bit wrong");
	chk_odd_par_bit: assert property (
		tx_st == urt_pkg::URT_TX_PAR && mode.par == urt_pkg::URT_PAR_ODD
		|-> serial_out_pin != ^(mode.len8 ? tx_shift_reg :
			{1'b0, tx_shift_reg[6:0]}))
		else $error("odd parity bit wrong");
	chk_zero_par_bit: assert property (
		tx_st == urt_pkg::URT_TX_PAR && mode.par == urt_pkg::URT_PAR_ZERO
		|-> !serial_out_pin)
		else $error("zero parity bit not low");
	chk_done_after_stop: assert property (
		$rose(tx_done_irq) |-> $past(tx_tick) &&
		($past(tx_st) == urt_pkg::URT_TX_STOP2 ||
		($past(tx_st) == urt_pkg::URT_TX_STOP1 && !$past(mode.stop2))))
		else $error("transmit done not after stop");
	chk_full_on_write: assert property (
		tb_wr && tx_on |=> tx_buffer_full_flag)
		else $error("full flag not set by write");
	chk_flag_pass: assert property (
		tx_on && transmit_status == 8'h02 && tx_st == urt_pkg::URT_TX_IDLE
		|=> transmit_status == 8'h03 ##1 transmit_status[1:0] != 2'b11
		|| tb_wr)
		else $error("status flags skipped 11");
	chk_busy_idle: assert property (
		tx_st == urt_pkg::URT_TX_IDLE |-> !tx_shift_busy_flag)
		else $error("busy flag set while idle");
	chk_no_par_err: assert property (
		mode.par inside {urt_pkg::URT_PAR_NONE, urt_pkg::URT_PAR_ZERO} &&
		rx_st == urt_pkg::URT_RX_STOP && rx_tick
		|=> !rx_error_status[`URT_ERR_PE])
		else $error("parity error without parity");
	chk_overrun_keep: assert property (
		rx_st == urt_pkg::URT_RX_STOP && rx_tick && rx_unread && !rxb_rd
		|=> rx_error_status[`URT_ERR_OVE] && $stable(rx_buffer))
		else $error("overrun not flagged or buffer changed");
	chk_filter_agree: assert property (
		mode.power && $past(mode.power) && rx_filt != $past(rx_filt)
		|-> $past(rx_s0) == $past(rx_s1))
		else $error("filter moved on disagreeing samples");

	cov_tx_frame: cover property (tx_done_irq);
	cov_back_to_back: cover property (tx_done_irq &&
		tx_st == urt_pkg::URT_TX_START);
	cov_rx_frame: cover property (rx_done_irq);
	cov_rx_error: cover property (rx_error_irq);

endmodule

// *** test/urt_remote.sv ***
// remote serial transceiver model facing the core's link pins
`timescale 1ns/10ps
module urt_remote #(
	parameter int T = 16
) (
	input wire logic pclk,
	input wire logic serial_out_pin,
	output logic serial_in_pin
);
	logic has_par = 1'b1;
	logic [7:0] rx_data;
	logic rx_par;
	logic [9:0] sh;
	int rx_cnt = 0;
	initial serial_in_pin = 1'b1;
	//////////////////////////////////////////////////////////////////////
	// receiver: mid-bit sampling after a falling edge, lsb first
	always begin
		@(negedge serial_out_pin);
		repeat (T / 2) @(posedge pclk);
		for (int i = 0; i < 9 + has_par; i++) begin
			repeat (T) @(posedge pclk);
			sh[i] = serial_out_pin;
		end
		rx_data = sh[7:0];
		rx_par = sh[8];
		rx_cnt++;
	end
	//////////////////////////////////////////////////////////////////////
	// sender: start, eight bits, optional parity, stop of given level
	task automatic send(input logic [7:0] d, input logic pe, input logic pb,
		input logic sv);
		logic [10:0] f;
		int n;
		f = pe ? {sv, pb, d, 1'b0} : {1'b1, sv, d, 1'b0};
		n = pe ? 11 : 10;
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			serial_in_pin <= f[i];
			repeat (T - 1) @(posedge pclk);
		end
		@(posedge pclk);
		serial_in_pin <= 1'b1;
	endtask
	// short low pulse on an idle line
	task automatic glitch(input int n);
		@(posedge pclk);
		serial_in_pin <= 1'b0;
		repeat (n) @(posedge pclk);
		serial_in_pin <= 1'b1;
	endtask
endmodule

// *** test/uart_tx_rx_parity_core_tb.sv ***
// self-checking bench of the serial core over apb and the serial link
`timescale 1ns/10ps
`include "urt_defines.svh"
module uart_tx_rx_parity_core_tb;
	localparam int T = 16;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, d;
	logic [31:0] pwdata, prdata, rd;
	logic tx_done_irq, rx_done_irq, rx_error_irq;
	logic [1:0] p;
	wire serial_in_pin;
	wire serial_out_pin;
	int num_errors = 0, total_checks = 0;
	int n_tx = 0, n_re = 0, n_any = 0, c, t, g;
	logic [7:0] td [7] = '{8'h5a, 8'h3c, 8'h0f, 8'hf1, 8'h77, 8'ha5, 8'h3c};
	logic [1:0] tp [7] = '{2'd3, 2'd3, 2'd2, 2'd2, 2'd1, 2'd0, 2'd3};
	logic [2:0] terr [7] = '{3'h0, 3'h4, 3'h0, 3'h4, 3'h0, 3'h2, 3'h4};
	logic [6:0] tbad = 7'b1011010, tstop = 7'b1011111, tsp = 7'b1000000;
	urt_core #(.AW(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
		.tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq),
		.rx_error_irq(rx_error_irq));
	urt_remote #(.T(T)) u_rem (.pclk(pclk), .serial_out_pin(serial_out_pin),
		.serial_in_pin(serial_in_pin));
	//////////////////////////////////////////////////////////////////////
	// clock, interrupt pulse counters, run limit
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (tx_done_irq === 1'b1) n_tx++;
		if (rx_error_irq === 1'b1) n_re++;
		if (rx_done_irq === 1'b1 || rx_error_irq === 1'b1) n_any++;
	end
	initial begin
		repeat (100000) @(posedge pclk);
		num_errors++;
		$display("[ERR] run limit reached");
		complete_run();
	end
	//////////////////////////////////////////////////////////////////////
	// helpers
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input string s, input logic [31:0] v,
		input logic [31:0] e);
		total_checks++;
		if (v !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", s, e, v);
		end
	endtask
	task automatic wait_for(ref int v, input int tgt);
		int k;
		k = 0;
		while (v < tgt && k < 5000) begin
			@(posedge pclk);
			k++;
		end
		check("wait", v >= tgt, 1);
		if (v < tgt) complete_run();
	endtask
	// one apb transfer: setup, access until pready, then release
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check("pready", k < 20, 1);
		if (k >= 20) complete_run();
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e,
		input string s);
		apb(1'b0, a, 32'h0);
		check(s, rd, e);
	endtask
	function automatic logic [31:0] md(input logic [1:0] pm, input logic s);
		return {24'h0, 3'b111, pm, 1'b1, 1'b0, s};
	endfunction
	function automatic logic pb(input logic [1:0] pm, input logic [7:0] v);
		if (pm == urt_pkg::URT_PAR_EVEN) return ^v;
		if (pm == urt_pkg::URT_PAR_ODD) return ~^v;
		return 1'b0;
	endfunction
	//////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rchk(`URT_OFS_MODE, 32'h01, "mode reset");
		rchk(`URT_OFS_RXBUF, 32'hff, "rxbuf reset");
		apb(1'b1, `URT_OFS_TSTAT, 32'h3);
		rchk(`URT_OFS_TSTAT, 32'h0, "tstat ro");
		apb(1'b0, 8'h1c, 32'h0);
		check("unmapped", err, 1'b1);
		check("pin idle", serial_out_pin, 1'b1);
		$display("reset test done");
		apb(1'b1, `URT_OFS_MODE, 32'h80);
		apb(1'b1, `URT_OFS_DIV, 32'h08);
		// every parity mode, stop length alternating
		for (int i = 0; i < 4; i++) begin
			p = i[1:0];
			d = 8'h36 + i[7:0];
			apb(1'b1, `URT_OFS_MODE, md(p, 1'b0) | {i[0], 1'b0});
			u_rem.has_par = (p != urt_pkg::URT_PAR_NONE);
			c = u_rem.rx_cnt;
			t = n_tx;
			rchk(`URT_OFS_TSTAT, 32'h0, "tstat idle");
			apb(1'b1, `URT_OFS_TXBUF, {24'h0, d});
			wait_for(n_tx, t + 1);
			check("tx data", u_rem.rx_data, d);
			if (u_rem.has_par) check("tx par", u_rem.rx_par, pb(p, d));
			check("frame before irq", u_rem.rx_cnt, c + 1);
			check("pin idle", serial_out_pin, 1'b1);
		end
		apb(1'b1, `URT_OFS_CTRL, 32'h0);
		t = n_tx;
		apb(1'b1, `URT_OFS_TXBUF, 32'h0b);
		wait_for(n_tx, t + 1);
		check("msb first", u_rem.rx_data, 8'hd0);
		apb(1'b1, `URT_OFS_CTRL, 32'h2);
		// seven character bits: bit 7 dropped, parity over bits 6:0
		apb(1'b1, `URT_OFS_MODE, md(urt_pkg::URT_PAR_EVEN, 1'b0) & 32'hfb);
		u_rem.has_par = 1'b0;
		t = n_tx;
		apb(1'b1, `URT_OFS_TXBUF, 32'hb6);
		wait_for(n_tx, t + 1);
		check("seven bits", u_rem.rx_data, 8'h36);
		u_rem.has_par = 1'b1;
		$display("tx parity test done");
		// back-to-back frames and status flags
		apb(1'b1, `URT_OFS_MODE, md(urt_pkg::URT_PAR_EVEN, 1'b0));
		c = u_rem.rx_cnt;
		t = n_tx;
		apb(1'b1, `URT_OFS_TXBUF, 32'ha1);
		rchk(`URT_OFS_TSTAT, 32'h1, "tstat loaded");
		apb(1'b1, `URT_OFS_TXBUF, 32'ha2);
		rchk(`URT_OFS_TSTAT, 32'h3, "tstat full");
		wait_for(u_rem.rx_cnt, c + 1);
		check("first", u_rem.rx_data, 8'ha1);
		wait_for(n_tx, t + 2);
		check("second", u_rem.rx_data, 8'ha2);
		rchk(`URT_OFS_TSTAT, 32'h0, "tstat done");
		$display("back-to-back test done");
		// reception in every parity mode with injected faults
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, `URT_OFS_MODE, md(tp[i], tsp[i]));
			g = n_any;
			c = n_re;
			u_rem.send(td[i], tp[i] != 2'd0, pb(tp[i], td[i]) ^ tbad[i],
				tstop[i]);
			wait_for(n_any, g + 1);
			check("err irq", n_re - c, terr[i] != 3'h0 && !tsp[i]);
			rchk(`URT_OFS_ERR, {29'h0, terr[i]}, "err");
			rchk(`URT_OFS_RXBUF, {24'h0, td[i]}, "rxbuf");
		end
		rchk(`URT_OFS_ERR, 32'h0, "err cleared");
		apb(1'b1, `URT_OFS_MODE, md(urt_pkg::URT_PAR_EVEN, 1'b0));
		g = n_any;
		u_rem.send(8'h11, 1'b1, 1'b0, 1'b1);
		u_rem.send(8'h22, 1'b1, 1'b0, 1'b1);
		wait_for(n_any, g + 2);
		rchk(`URT_OFS_ERR, 32'h1, "overrun");
		rchk(`URT_OFS_RXBUF, 32'h11, "rxbuf kept");
		$display("rx test done");
		// noise and false start rejection
		g = n_any;
		u_rem.glitch(1);
		repeat (4) @(posedge pclk);
		u_rem.glitch(4);
		repeat (20 * T) @(posedge pclk);
		check("no frame", n_any, g);
		$display("filter test done");
		// dropping transmit enable mid-frame
		apb(1'b1, `URT_OFS_TXBUF, 32'h55);
		apb(1'b1, `URT_OFS_MODE, md(urt_pkg::URT_PAR_EVEN, 1'b0) & 32'hbf);
		// the disable lands at this edge; the pin follows one edge later
		repeat (2) @(posedge pclk);
		check("pin after stop", serial_out_pin, 1'b1);
		rchk(`URT_OFS_TSTAT, 32'h0, "tstat reset");
		$display("disable test done");
		complete_run();
	end
endmodule
